// ===== tpw_pkg.sv
// shared constants and types of the phase correct pwm timer
`default_nettype none
package tpw_pkg;
	// register byte offsets
	localparam logic [7:0] TPW_OFF_CTRL_A = 8'h00;
	localparam logic [7:0] TPW_OFF_CTRL_B = 8'h04;
	localparam logic [7:0] TPW_OFF_COUNT  = 8'h08;
	localparam logic [7:0] TPW_OFF_CMP    = 8'h0c;
	localparam logic [7:0] TPW_OFF_FLAGS  = 8'h10;
	localparam logic [7:0] TPW_OFF_IRQEN  = 8'h14;
	localparam logic [7:0] TPW_OFF_ASYNC  = 8'h18;
	localparam logic [7:0] TPW_OFF_DIR    = 8'h1c;
	// field positions
	localparam int TPW_COM_POS  = 6;
	localparam int TPW_WGM_POS  = 0;
	localparam int TPW_CS_POS   = 0;
	localparam int TPW_OVF_POS  = 0;
	localparam int TPW_CMP_POS  = 1;
	localparam int TPW_CTLB_POS = 0;
	localparam int TPW_CMPB_POS = 1;
	localparam int TPW_CNTB_POS = 2;
	localparam int TPW_ASEL_POS = 5;
	localparam int TPW_XSEL_POS = 6;
	localparam int TPW_DIR_POS  = 0;
	// codes and limits
	localparam logic [1:0] TPW_WGM_PHASE  = 2'h1;
	localparam logic [1:0] TPW_COM_NONINV = 2'h2;
	localparam logic [1:0] TPW_COM_INV    = 2'h3;
	localparam logic [2:0] TPW_CS_STOP    = 3'h0;
	localparam logic [7:0] TPW_MAX        = 8'hff;
	localparam logic [7:0] TPW_BOTTOM     = 8'h00;
	localparam logic [1:0] TPW_XFER_EDGES = 2'h2;
	localparam logic [7:0] TPW_RST_BYTE   = 8'h00;

	typedef struct packed {
		logic [1:0] com;
		logic [1:0] wgm;
	} tpw_ctrl_t;

	typedef enum logic {
		TPW_UP   = 1'b0,
		TPW_DOWN = 1'b1
	} tpw_dir_t;

	// prescaler mask: tick when all masked bits of the count are set
	function automatic logic [9:0] tpw_div_mask(input logic [2:0] cs);
		case (cs)
			3'h2:    tpw_div_mask = 10'h007;
			3'h3:    tpw_div_mask = 10'h01f;
			3'h4:    tpw_div_mask = 10'h03f;
			3'h5:    tpw_div_mask = 10'h07f;
			3'h6:    tpw_div_mask = 10'h0ff;
			3'h7:    tpw_div_mask = 10'h3ff;
			default: tpw_div_mask = 10'h000;
		endcase
	endfunction
endpackage
`default_nettype wire

// ===== tpw_hold.sv
// temporary holding register with update busy flag
`timescale 1ns/100ps
`default_nettype none
module tpw_hold
	import tpw_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	input  wire logic       asyncMode,
	input  wire logic       srcEdge,
	output logic            commit,
	output logic [7:0]      commitData,
	output logic            busy
);
	logic [7:0] temp_q, temp_d;
	logic       busy_q, busy_d;
	logic [1:0] edges_q, edges_d;
	logic       commit_q, commit_d;

	always_comb begin
		temp_d   = temp_q;
		busy_d   = busy_q;
		edges_d  = edges_q;
		commit_d = 1'b0;
		if (wrEn && !asyncMode) begin
			temp_d   = wrData;
			busy_d   = 1'b0;
			commit_d = 1'b1;
		end else if (wrEn && !busy_q) begin
			temp_d  = wrData;
			busy_d  = 1'b1;
			edges_d = 2'h0;
		end else if (busy_q && srcEdge) begin
			if (edges_q == TPW_XFER_EDGES - 2'h1) begin
				busy_d   = 1'b0;
				commit_d = 1'b1;
			end else begin
				edges_d = edges_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			temp_q   <= TPW_RST_BYTE;
			busy_q   <= 1'b0;
			edges_q  <= 2'h0;
			commit_q <= 1'b0;
		end else begin
			temp_q   <= temp_d;
			busy_q   <= busy_d;
			edges_q  <= edges_d;
			commit_q <= commit_d;
		end
	end

	assign commit     = commit_q;
	assign commitData = temp_q;
	assign busy       = busy_q;
endmodule // tpw_hold
`default_nettype wire

// ===== tpw_timer.sv
// 8-bit phase correct pwm timer with asynchronous clocking, apb slave
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module tpw_timer
	import tpw_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        asyncClockInput,
	input  wire logic        crystalInputPin,
	input  wire logic        powerDown,
	output logic             compareOutputPin,
	output logic             compareOutputOe,
	output logic             oscEnable,
	output logic             timerWake
);
	////////////////////////////////////////////////////////////////////
	logic        oscMeta_q, oscSync_q, xtalMeta_q, xtalSync_q;
	logic        srcLevel_q, srcLevel, asyncEdge, srcTick;
	logic        asyncClockSelect_q, externalClockSelect_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			oscMeta_q  <= 1'b0;
			oscSync_q  <= 1'b0;
			xtalMeta_q <= 1'b0;
			xtalSync_q <= 1'b0;
			srcLevel_q <= 1'b0;
		end else begin
			oscMeta_q  <= asyncClockInput;
			oscSync_q  <= oscMeta_q;
			xtalMeta_q <= crystalInputPin;
			xtalSync_q <= xtalMeta_q;
			srcLevel_q <= srcLevel;
		end
	end

	// switching source may fake one edge; software reloads after it
	assign srcLevel  = externalClockSelect_q ? xtalSync_q : oscSync_q;
	assign asyncEdge = srcLevel && !srcLevel_q && !powerDown;
	assign srcTick   = asyncClockSelect_q ? asyncEdge : 1'b1;
	assign oscEnable = asyncClockSelect_q && !powerDown;

	////////////////////////////////////////////////////////////////////
	logic        wrAccess, wrCtrlA, wrCtrlB, wrCount, wrCmp;
	logic        wrFlags, wrIrqEn, wrAsync, wrDir;
	logic [31:0] rdData_d, prdata_q;
	logic        mapped, pslverr_q;
	tpw_ctrl_t   controlRegA_q;
	logic [7:0]  counterValue_q, counterReadback_q, compareValue_q;
	logic [2:0]  clockSelect_q;
	logic        overflowFlag_q, compareMatchFlag_q;
	logic        overflowIrqEnable_q, compareIrqEnable_q, portDirOut_q;
	logic        counterUpdateBusy, compareUpdateBusy, controlUpdateBusy;

	assign wrAccess = psel && penable && pwrite && !pslverr_q;
	assign wrCtrlA  = wrAccess && paddr == TPW_OFF_CTRL_A;
	assign wrCtrlB  = wrAccess && paddr == TPW_OFF_CTRL_B;
	assign wrCount  = wrAccess && paddr == TPW_OFF_COUNT;
	assign wrCmp    = wrAccess && paddr == TPW_OFF_CMP;
	assign wrFlags  = wrAccess && paddr == TPW_OFF_FLAGS;
	assign wrIrqEn  = wrAccess && paddr == TPW_OFF_IRQEN;
	assign wrAsync  = wrAccess && paddr == TPW_OFF_ASYNC;
	assign wrDir    = wrAccess && paddr == TPW_OFF_DIR;

	always_comb begin
		rdData_d = 32'h0;
		mapped   = 1'b1;
		case (paddr)
			TPW_OFF_CTRL_A: begin
				rdData_d[TPW_COM_POS +: 2] = controlRegA_q.com;
				rdData_d[TPW_WGM_POS +: 2] = controlRegA_q.wgm;
			end
			TPW_OFF_CTRL_B: rdData_d[TPW_CS_POS +: 3] = clockSelect_q;
			TPW_OFF_COUNT: begin
				rdData_d[7:0] = asyncClockSelect_q ? counterReadback_q
					: counterValue_q;
			end
			TPW_OFF_CMP: rdData_d[7:0] = compareValue_q;
			TPW_OFF_FLAGS: begin
				rdData_d[TPW_OVF_POS] = overflowFlag_q;
				rdData_d[TPW_CMP_POS] = compareMatchFlag_q;
			end
			TPW_OFF_IRQEN: begin
				rdData_d[TPW_OVF_POS] = overflowIrqEnable_q;
				rdData_d[TPW_CMP_POS] = compareIrqEnable_q;
			end
			TPW_OFF_ASYNC: begin
				rdData_d[TPW_CTLB_POS] = controlUpdateBusy;
				rdData_d[TPW_CMPB_POS] = compareUpdateBusy;
				rdData_d[TPW_CNTB_POS] = counterUpdateBusy;
				rdData_d[TPW_ASEL_POS] = asyncClockSelect_q;
				rdData_d[TPW_XSEL_POS] = externalClockSelect_q;
			end
			TPW_OFF_DIR: rdData_d[TPW_DIR_POS] = portDirOut_q;
			default: mapped = 1'b0;
		endcase
	end

	// read data and error latched in the setup cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata_q  <= 32'h0;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= rdData_d;
			pslverr_q <= !mapped;
		end
	end

	assign prdata  = prdata_q;
	assign pslverr = pslverr_q && psel && penable;
	assign pready  = 1'b1;

	////////////////////////////////////////////////////////////////////
	logic       ctrlCommit, cntCommit, cmpCommit;
	logic [7:0] ctrlData, cntData, cmpData;

	tpw_hold ctrlHold (
		.clk        (clk),
		.rst        (rst),
		.wrEn       (wrCtrlA),
		.wrData     (pwdata[7:0]),
		.asyncMode  (asyncClockSelect_q),
		.srcEdge    (asyncEdge),
		.commit     (ctrlCommit),
		.commitData (ctrlData),
		.busy       (controlUpdateBusy)
	);

	tpw_hold cntHold (
		.clk        (clk),
		.rst        (rst),
		.wrEn       (wrCount),
		.wrData     (pwdata[7:0]),
		.asyncMode  (asyncClockSelect_q),
		.srcEdge    (asyncEdge),
		.commit     (cntCommit),
		.commitData (cntData),
		.busy       (counterUpdateBusy)
	);

	tpw_hold cmpHold (
		.clk        (clk),
		.rst        (rst),
		.wrEn       (wrCmp),
		.wrData     (pwdata[7:0]),
		.asyncMode  (asyncClockSelect_q),
		.srcEdge    (asyncEdge),
		.commit     (cmpCommit),
		.commitData (cmpData),
		.busy       (compareUpdateBusy)
	);

	////////////////////////////////////////////////////////////////////
	logic      ovfSet, cmpSet, matchEn, cmpHit, phaseMode, timerTick;
	logic      ovfFlag_d, cmpFlag_d, wakePend_q, wakePend_d, timerWake_q;
	logic      timerWake_d, wave_q, wave_d;
	logic [9:0] preCnt_q, preCnt_d;
	logic [7:0] cnt_d, cmpActive_q, cmpActive_d, readback_d;
	tpw_dir_t  dir_q, dir_d, effDir;

	assign phaseMode = controlRegA_q.wgm == TPW_WGM_PHASE;
	assign timerTick = srcTick && clockSelect_q != TPW_CS_STOP
		&& (preCnt_q & tpw_div_mask(clockSelect_q))
		== tpw_div_mask(clockSelect_q);
	// counter or compare transfer in flight blocks the compare unit
	assign matchEn = !(asyncClockSelect_q
		&& (counterUpdateBusy || compareUpdateBusy));

	always_comb begin
		preCnt_d    = preCnt_q;
		cnt_d       = counterValue_q;
		dir_d       = dir_q;
		cmpActive_d = cmpActive_q;
		wave_d      = wave_q;
		ovfSet      = 1'b0;
		readback_d  = asyncEdge ? counterValue_q : counterReadback_q;
		if (!phaseMode)
			cmpActive_d = compareValue_q;
		if (srcTick && clockSelect_q != TPW_CS_STOP)
			preCnt_d = preCnt_q + 10'h1;
		if (timerTick && phaseMode) begin
			if (dir_q == TPW_UP) begin
				if (counterValue_q == TPW_MAX) begin
					cnt_d = TPW_MAX - 8'h1;
					dir_d = TPW_DOWN;
				end else begin
					cnt_d = counterValue_q + 8'h1;
				end
			end else begin
				if (counterValue_q == TPW_BOTTOM) begin
					cnt_d = TPW_BOTTOM + 8'h1;
					dir_d = TPW_UP;
				end else begin
					cnt_d = counterValue_q - 8'h1;
				end
			end
			ovfSet = cnt_d == TPW_BOTTOM;
			if (cnt_d == TPW_MAX)
				cmpActive_d = compareValue_q;
		end else if (timerTick) begin
			cnt_d  = counterValue_q + 8'h1;
			dir_d  = TPW_UP;
			ovfSet = counterValue_q == TPW_MAX;
		end
		// bottom and top count as turning points for the match action
		if (cnt_d == TPW_BOTTOM)
			effDir = TPW_UP;
		else if (cnt_d == TPW_MAX)
			effDir = TPW_DOWN;
		else
			effDir = dir_d;
		cmpHit = timerTick && matchEn && cnt_d == cmpActive_q;
		if (timerTick && phaseMode && controlRegA_q.com[1]) begin
			if (cmpActive_q == TPW_MAX) begin
				if (cnt_d == TPW_MAX && matchEn)
					wave_d = controlRegA_q.com == TPW_COM_NONINV;
			end else if (cmpHit) begin
				if (effDir == TPW_UP)
					wave_d = controlRegA_q.com == TPW_COM_INV;
				else
					wave_d = controlRegA_q.com == TPW_COM_NONINV;
			end
		end
		if (cntCommit)
			cnt_d = cntData;
	end

	assign cmpSet = cmpHit;

	always_comb begin
		ovfFlag_d = overflowFlag_q;
		cmpFlag_d = compareMatchFlag_q;
		if (wrFlags && pwdata[TPW_OVF_POS])
			ovfFlag_d = 1'b0;
		if (wrFlags && pwdata[TPW_CMP_POS])
			cmpFlag_d = 1'b0;
		if (ovfSet)
			ovfFlag_d = 1'b1;
		if (cmpSet)
			cmpFlag_d = 1'b1;
		wakePend_d  = wakePend_q;
		timerWake_d = 1'b0;
		if (wakePend_q && timerTick) begin
			timerWake_d = 1'b1;
			wakePend_d  = 1'b0;
		end
		if ((ovfSet && overflowIrqEnable_q) || (cmpSet && compareIrqEnable_q))
			wakePend_d = 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			preCnt_q           <= 10'h000;
			counterValue_q     <= TPW_RST_BYTE;
			counterReadback_q  <= TPW_RST_BYTE;
			dir_q              <= TPW_UP;
			cmpActive_q        <= TPW_RST_BYTE;
			wave_q             <= 1'b0;
			overflowFlag_q     <= 1'b0;
			compareMatchFlag_q <= 1'b0;
			wakePend_q         <= 1'b0;
			timerWake_q        <= 1'b0;
		end else begin
			preCnt_q           <= preCnt_d;
			counterValue_q     <= cnt_d;
			counterReadback_q  <= readback_d;
			dir_q              <= dir_d;
			cmpActive_q        <= cmpActive_d;
			wave_q             <= wave_d;
			overflowFlag_q     <= ovfFlag_d;
			compareMatchFlag_q <= cmpFlag_d;
			wakePend_q         <= wakePend_d;
			timerWake_q        <= timerWake_d;
		end
	end

	// software registers; transferred ones load on their commit pulse
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			controlRegA_q         <= '0;
			compareValue_q        <= TPW_RST_BYTE;
			clockSelect_q         <= TPW_CS_STOP;
			overflowIrqEnable_q   <= 1'b0;
			compareIrqEnable_q    <= 1'b0;
			asyncClockSelect_q    <= 1'b0;
			externalClockSelect_q <= 1'b0;
			portDirOut_q          <= 1'b0;
		end else begin
			if (ctrlCommit) begin
				controlRegA_q.com <= ctrlData[TPW_COM_POS +: 2];
				controlRegA_q.wgm <= ctrlData[TPW_WGM_POS +: 2];
			end
			if (cmpCommit)
				compareValue_q <= cmpData;
			if (wrCtrlB)
				clockSelect_q <= pwdata[TPW_CS_POS +: 3];
			if (wrIrqEn) begin
				overflowIrqEnable_q <= pwdata[TPW_OVF_POS];
				compareIrqEnable_q  <= pwdata[TPW_CMP_POS];
			end
			if (wrAsync) begin
				asyncClockSelect_q    <= pwdata[TPW_ASEL_POS];
				externalClockSelect_q <= pwdata[TPW_XSEL_POS];
			end
			if (wrDir)
				portDirOut_q <= pwdata[TPW_DIR_POS];
		end
	end

	assign compareOutputPin = wave_q && controlRegA_q.com[1];
	assign compareOutputOe  = portDirOut_q;
	assign timerWake        = timerWake_q;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	topHold_a: assert property (timerTick && phaseMode && !cntCommit
		&& counterValue_q == TPW_MAX |=> counterValue_q == 8'hfe
		&& dir_q == TPW_DOWN)
		else $error("max not held one tick");
	upStep_a: assert property (timerTick && phaseMode && !cntCommit
		&& dir_q == TPW_UP && counterValue_q != TPW_MAX
		|=> counterValue_q == $past(counterValue_q) + 8'h1)
		else $error("up count step wrong");
	bottomOvf_a: assert property (timerTick && phaseMode
		&& dir_q == TPW_DOWN && counterValue_q == 8'h01
		|=> overflowFlag_q)
		else $error("overflow not set at bottom");
	clearUp_a: assert property (cmpHit && phaseMode && effDir == TPW_UP
		&& controlRegA_q.com == TPW_COM_NONINV
		&& cmpActive_q != TPW_MAX |=> !wave_q)
		else $error("non-inverting up match not cleared");
	setUpInv_a: assert property (cmpHit && phaseMode && effDir == TPW_UP
		&& controlRegA_q.com == TPW_COM_INV
		&& cmpActive_q != TPW_MAX |=> wave_q)
		else $error("inverting up match not set");
	idleHold_a: assert property (!timerTick && !cntCommit
		|=> $stable(counterValue_q))
		else $error("counter moved without tick");
	busyMask_a: assert property (asyncClockSelect_q && compareUpdateBusy
		&& !wrFlags |=> !$rose(compareMatchFlag_q))
		else $error("compare active during transfer");
	bufLoad_a: assert property (phaseMode && $past(phaseMode)
		&& cmpActive_q != $past(cmpActive_q) && !$past(cntCommit)
		|-> counterValue_q == TPW_MAX)
		else $error("compare buffer loaded off top");
	asyncCommit_a: assert property (asyncClockSelect_q
		&& $past(asyncClockSelect_q) && cmpCommit
		|-> $past(asyncEdge))
		else $error("transfer without async edge");
	readSync_a: assert property (!asyncEdge
		|=> $stable(counterReadback_q))
		else $error("readback changed between edges");
	wakeTick_a: assert property (timerWake |-> $past(timerTick))
		else $error("wake not on timer tick");
	prescale8_a: assert property (timerTick && clockSelect_q == 3'h2
		|-> preCnt_q[2:0] == 3'h7)
		else $error("prescale by eight wrong");
endmodule // tpw_timer
`default_nettype wire

// ===== tpw_load.sv
// external load with pull-down on the pwm pad, totals its high time
`timescale 1ns/100ps
`default_nettype none
module tpw_load (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        pinValue,
	input  wire logic        pinOe,
	input  wire logic        clear,
	input  wire logic        measure,
	output logic             padLevel,
	output logic [15:0]      highCount_q
);
	logic [15:0] highCount_d;
	// an undriven pad sinks to the pull-down, never keeps the last level
	assign padLevel = pinOe ? pinValue : 1'b0;
	always_comb begin
		highCount_d = highCount_q;
		if (clear) begin
			highCount_d = 16'h0000;
		end else if (measure && padLevel) begin
			highCount_d = highCount_q + 16'h0001;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			highCount_q <= 16'h0000;
		end else begin
			highCount_q <= highCount_d;
		end
	end
endmodule // tpw_load
`default_nettype wire

// ===== tpw_timer_bench.sv
// self-checking bench of the phase correct pwm timer
`timescale 1ns/100ps
`default_nettype none
module tpw_timer_bench
	import tpw_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        asyncClockInput = 1'b0;
	logic        crystalInputPin = 1'b0;
	logic        powerDown = 1'b0;
	logic        compareOutputPin;
	logic        compareOutputOe;
	logic        oscEnable;
	logic        timerWake;
	logic        clearLoad = 1'b0;
	logic        measureOn = 1'b0;
	logic        padLevel;
	logic [15:0] highCount;
	logic [31:0] rdData;
	logic        rdErr;
	int          numErrors = 0;
	int          compares = 0;
	int          seed = 32'h53fb;
	int          divCnt = 0;
	int          cyc = 0;
	int          hi;
	int          t1;
	int          c;
	int          cmpList[6] = '{0, 1, 128, 200, 255, 0};

	tpw_timer tpw_timer_inst (.clk(clk), .rst(rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.asyncClockInput(asyncClockInput), .crystalInputPin(crystalInputPin),
		.powerDown(powerDown), .compareOutputPin(compareOutputPin),
		.compareOutputOe(compareOutputOe), .oscEnable(oscEnable),
		.timerWake(timerWake));
	tpw_load tpw_load_inst (.clk(clk), .rst(rst), .pinValue(compareOutputPin),
		.pinOe(compareOutputOe), .clear(clearLoad), .measure(measureOn),
		.padLevel(padLevel), .highCount_q(highCount));

	initial begin
		forever #5 clk = ~clk;
	end
	// oscillator at a tenth of the cpu clock, well inside the 4x margin
	always @(posedge clk) begin
		cyc <= cyc + 1;
		divCnt <= (divCnt == 34) ? 0 : divCnt + 1;
		if (divCnt % 5 == 4) begin
			asyncClockInput <= ~asyncClockInput;
		end
		if (divCnt % 7 == 6) begin
			crystalInputPin <= ~crystalInputPin;
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic complete_run();
		if (numErrors == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_up(input string name);
		numErrors++;
		$display("[FAIL] %s expected done seen timeout", name);
		complete_run();
	endtask
	task automatic apb(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		for (n = 0; pready !== 1'b1 && n < 16; n++) begin
			@(posedge clk);
		end
		if (pready !== 1'b1) begin
			give_up("pready");
		end
		rdData = prdata;
		rdErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_idle();
		int n;
		for (n = 0; n < 60; n++) begin
			apb(TPW_OFF_ASYNC, 1'b0, 32'h0);
			if (rdData[2:0] === 3'h0) begin
				break;
			end
		end
		if (rdData[2:0] !== 3'h0) begin
			give_up("update busy");
		end
	endtask
	// counts pad-high clocks over exactly len clocks
	task automatic measure(input int len, output int high);
		@(posedge clk);
		clearLoad <= 1'b1;
		@(posedge clk);
		clearLoad <= 1'b0;
		measureOn <= 1'b1;
		repeat (len) @(posedge clk);
		measureOn <= 1'b0;
		@(posedge clk);
		high = highCount;
	endtask
	function automatic int absd(input int a, input int b);
		return (a > b) ? a - b : b - a;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		apb(TPW_OFF_ASYNC, 1'b0, 32'h0);
		check("async status reset", rdData, 32'h0);
		apb(8'h20, 1'b0, 32'h0);
		check("unmapped error", {31'h0, rdErr}, 32'h1);
		apb(TPW_OFF_DIR, 1'b1, 32'h1);
		// register outputs settle one edge after the access edge
		@(posedge clk);
		check("pin enable", {31'h0, compareOutputOe}, 32'h1);
		apb(TPW_OFF_CTRL_B, 1'b1, 32'h1);
		cmpList[5] = $random(seed) & 8'hff;
		// duty of every compare case in both polarities, 2c of 510 ticks non-inverting, 510-2c inverting
		for (int inv = 0; inv < 2; inv++) begin
			for (int k = 0; k < 6; k++) begin
				c = cmpList[k];
				apb(TPW_OFF_CTRL_A, 1'b1, inv ? 32'hc1 : 32'h81);
				apb(TPW_OFF_CMP, 1'b1, 32'(c));
				repeat (1100) @(posedge clk);
				measure(510, hi);
				check("duty", 32'(hi), inv ? 32'(510 - 2 * c) : 32'(2 * c));
			end
		end
		apb(TPW_OFF_CTRL_A, 1'b1, 32'h81);
		apb(TPW_OFF_CMP, 1'b1, 32'hff);
		apb(TPW_OFF_DIR, 1'b1, 32'h0);
		repeat (1100) @(posedge clk);
		measure(510, hi);
		check("pad when input", 32'(hi), 32'h0);
		apb(TPW_OFF_DIR, 1'b1, 32'h1);
		apb(TPW_OFF_CMP, 1'b1, 32'd100);
		apb(TPW_OFF_CTRL_B, 1'b1, 32'h2);
		repeat (9000) @(posedge clk);
		measure(4080, hi);
		check("duty div 8", 32'(hi), 32'd1600);
		apb(TPW_OFF_CTRL_B, 1'b1, 32'h1);
		// spacing of two overflow flags, within polling slack
		for (int p = 0; p < 2; p++) begin
			apb(TPW_OFF_FLAGS, 1'b1, 32'h1);
			for (int n = 0; n < 300; n++) begin
				apb(TPW_OFF_FLAGS, 1'b0, 32'h0);
				if (rdData[0] === 1'b1) begin
					break;
				end
			end
			if (rdData[0] !== 1'b1) begin
				give_up("overflow flag");
			end
			if (p == 1) begin
				check("overflow spacing", 32'(absd(cyc - t1, 510) <= 6), 32'h1);
			end
			t1 = cyc;
		end
		// clock switch: select, rewrite, wait busy, read back
		apb(TPW_OFF_ASYNC, 1'b1, 32'h20);
		@(posedge clk);
		check("oscillator on", {31'h0, oscEnable}, 32'h1);
		apb(TPW_OFF_CMP, 1'b1, 32'h11);
		apb(TPW_OFF_CMP, 1'b1, 32'h22);
		apb(TPW_OFF_ASYNC, 1'b0, 32'h0);
		check("compare busy", {31'h0, rdData[1]}, 32'h1);
		wait_idle();
		apb(TPW_OFF_CMP, 1'b0, 32'h0);
		check("write during busy", rdData, 32'h11);
		apb(TPW_OFF_COUNT, 1'b1, 32'h40);
		wait_idle();
		// readback copy only refreshes on the next async edge
		repeat (12) @(posedge clk);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		check("count landed", 32'(absd(rdData[7:0], 8'h40) <= 3), 32'h1);
		t1 = rdData[7:0];
		repeat (97) @(posedge clk);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		check("async ticks", 32'(absd(rdData[7:0], t1) inside {[9:11]}), 32'h1);
		powerDown <= 1'b1;
		repeat (10) @(posedge clk);
		check("oscillator off", {31'h0, oscEnable}, 32'h0);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		t1 = rdData[7:0];
		repeat (100) @(posedge clk);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		check("frozen count", rdData, 32'(t1));
		powerDown <= 1'b0;
		// oscillator settling time, scaled far below the real figure
		repeat (50) @(posedge clk);
		apb(TPW_OFF_FLAGS, 1'b1, 32'h3);
		apb(TPW_OFF_IRQEN, 1'b1, 32'h1);
		for (int n = 0; n < 6000 && timerWake !== 1'b1; n++) begin
			@(posedge clk);
		end
		check("wake pulse", {31'h0, timerWake}, 32'h1);
		apb(TPW_OFF_FLAGS, 1'b0, 32'h0);
		check("overflow flag", {31'h0, rdData[0]}, 32'h1);
		// one async cycle must pass before sleeping again
		apb(TPW_OFF_CTRL_A, 1'b1, 32'h81);
		wait_idle();
		// external clock pin: one tick every 14 clocks
		apb(TPW_OFF_ASYNC, 1'b1, 32'h60);
		apb(TPW_OFF_COUNT, 1'b1, 32'h10);
		wait_idle();
		repeat (16) @(posedge clk);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		t1 = rdData[7:0];
		repeat (137) @(posedge clk);
		apb(TPW_OFF_COUNT, 1'b0, 32'h0);
		check("pin ticks", 32'(absd(rdData[7:0], t1)), 32'd10);
		complete_run();
	end
endmodule // tpw_timer_bench
`default_nettype wire
